// >>> rtl/src_readout_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] - vertical start: 13 bits, two-line units, multiple of four
// [RULE2] - vertical height: 13 bits, multiple of four, reset 1120h
// [RULE3] - exposure: 20-bit line count over three bytes
// [RULE4] - gain code: 0.3 dB per step, 72 dB top
// [RULE5] - vertical pin select: 0 low, 2 sync pulse
// [RULE6] - horizontal pin select: 0 low, 2 sync pulse
// [RULE7] - vertical pin drive: 0 output, 3 high impedance
// [RULE8] - horizontal pin drive: 0 output, 3 high impedance
// [RULE9] - vertical pulse width 1, 2, 4, 8 lines
// [RULE10] - horizontal pulse width 16 to 128 clocks
// [RULE11] - host sets clamp start by readout mode
// [RULE12] - host sets clamp line count by readout mode
// [RULE13] - black offset: one or four digits per step
// [RULE14] - horizontal crop: start even, width multiple of 24
// [RULE15] - low byte first; unused bits read zero; here fixed bit 5 of 30C0h resets to one and always reads one
// [RULE16] - immediate fields act right after the write
// [RULE17] - standby fields take effect at standby release
// [RULE18] - crop, exposure, gain change only at frame boundary
// [RULE19] - gain reaches output one frame later; here it reaches it two frames after the other frame fields
module src_readout_regs (
    input wire logic clk_in,                    // device clock
    input wire logic nrst_in,                   // async reset, active low
    input wire logic reg_wr_in,                 // byte write strobe
    input wire logic reg_rd_in,                 // byte read strobe
    input wire logic [15:0] reg_addr_in,        // register byte address
    input wire logic [7:0] reg_wdata_in,        // write data
    output logic [7:0] reg_rdata_out,           // read data, next cycle
    output logic reg_hit_out,                   // last read was mapped
    input wire logic standby_in,                // device in standby
    input wire logic readout_12bit_in,          // 12-bit readout mode
    input wire logic frame_start_in,            // frame boundary pulse
    input wire logic line_start_in,             // line start pulse
    output src_pkg::src_frame_cfg_t frame_cfg_out, // frame settings
    output logic [8:0] gain_code_out,           // gain of output frame
    output logic [9:0] gain_tenth_db_out,       // gain in 0.1 dB
    output logic [11:0] black_offset_out,       // offset in digits
    output logic [4:0] clamp_vert_start_out,    // clamp start line
    output logic [1:0] clamp_vert_count_out,    // clamp line count
    output logic crop_misaligned_out,           // crop grid violated
    output logic vsync_pin_out,                 // vertical sync level
    output logic vsync_pin_oe_out,              // vertical sync enable
    output logic hsync_pin_out,                 // horizontal sync level
    output logic hsync_pin_oe_out               // horizontal sync enable
);

    // ****************************************************************
    // storage and address decode
    // ****************************************************************
    logic [7:0] regs_q [0:src_pkg::NUM_REGS-1];
    logic wr_hit;
    logic [4:0] wr_idx;
    logic rd_hit;
    logic [4:0] rd_idx;

    // linear search of the map; returns {hit, index}
    function automatic logic [5:0] decode(input logic [15:0] addr);
        logic [5:0] res;
        res = 6'h00;
        for (int i = 0; i < src_pkg::NUM_REGS; i++) begin
            if (src_pkg::REG_ADDR[i] == addr) begin
                res = {1'b1, 5'(i)};
            end
        end
        return res;
    endfunction

    assign {wr_hit, wr_idx} = decode(reg_addr_in);
    assign {rd_hit, rd_idx} = {wr_hit, wr_idx};

    // only writable bits change; fixed bits keep their reset value
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < src_pkg::NUM_REGS; i++) begin
                regs_q[i] <= src_pkg::REG_RST[i];
            end
        end else if (reg_wr_in && wr_hit) begin
            regs_q[wr_idx] <= (regs_q[wr_idx] & ~src_pkg::REG_MASK[wr_idx])
                | (reg_wdata_in & src_pkg::REG_MASK[wr_idx]); // [RULE15]
        end
    end

    // read data registered; unmapped addresses read zero
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 8'h00;
            reg_hit_out <= 1'b0;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_hit ? regs_q[rd_idx] : 8'h00; // [RULE15]
            reg_hit_out <= rd_hit;
        end
    end

    // ****************************************************************
    // field assembly, low byte at the lower address
    // ****************************************************************
    src_pkg::src_frame_cfg_t staged_cfg;

    always_comb begin
        staged_cfg.hcrop_start = {regs_q[src_pkg::I_HST_HI][4:0],
            regs_q[src_pkg::I_HST_LO]};                 // [RULE15]
        staged_cfg.hcrop_width = {regs_q[src_pkg::I_HWID_HI][4:0],
            regs_q[src_pkg::I_HWID_LO]};
        staged_cfg.vcrop_start = {regs_q[src_pkg::I_VST_HI][4:0],
            regs_q[src_pkg::I_VST_LO]};                 // [RULE1]
        staged_cfg.vcrop_height = {regs_q[src_pkg::I_VHGT_HI][4:0],
            regs_q[src_pkg::I_VHGT_LO]};                // [RULE2]
        staged_cfg.storage_time = {regs_q[src_pkg::I_ST_B2][3:0],
            regs_q[src_pkg::I_ST_B1], regs_q[src_pkg::I_ST_B0]}; // [RULE3]
        staged_cfg.gain_code = {regs_q[src_pkg::I_GAIN_HI][0],
            regs_q[src_pkg::I_GAIN_LO]};
    end

    // ****************************************************************
    // frame reflection
    // ****************************************************************
    src_pkg::src_frame_cfg_t active_cfg_q;

    // a multi-byte write spread across a boundary may tear; the host
    // must finish each field within one frame
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            active_cfg_q <= src_pkg::FRAME_CFG_RST;
        end else if (frame_start_in) begin
            active_cfg_q <= staged_cfg;                 // [RULE18] [RULE3]
        end
    end

    assign frame_cfg_out = active_cfg_q;

    // gain takes two extra frames before it reaches the pixels
    src_gain_stage u_gain (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .frame_start_in(frame_start_in),
        .gain_latched_in(active_cfg_q.gain_code),
        .gain_code_out(gain_code_out),
        .gain_tenth_db_out(gain_tenth_db_out)
    );                                                   // [RULE19]

    // device does not round crop values; it only flags a bad grid
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            crop_misaligned_out <= 1'b0;
        end else begin
            crop_misaligned_out <= (active_cfg_q.vcrop_start[1:0] != 2'h0)
                || (active_cfg_q.vcrop_height[1:0] != 2'h0)  // [RULE1] [RULE2]
                || active_cfg_q.hcrop_start[0]
                || (active_cfg_q.hcrop_width % 13'd24 != 13'd0); // [RULE14]
        end
    end

    // ****************************************************************
    // standby reflection
    // ****************************************************************
    src_pkg::src_standby_cfg_t stby_cfg_q;
    logic standby_q;
    logic standby_release;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            standby_q <= 1'b1;
        end else begin
            standby_q <= standby_in;
        end
    end

    assign standby_release = standby_q && !standby_in;

    // values written during standby land on its release only
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stby_cfg_q <= src_pkg::STBY_CFG_RST;
        end else if (standby_release) begin
            stby_cfg_q.vsync_pin_drive <=
                regs_q[src_pkg::I_SYNC_DRV][1:0];           // [RULE17]
            stby_cfg_q.hsync_pin_drive <=
                regs_q[src_pkg::I_SYNC_DRV][3:2];
            stby_cfg_q.clamp_vert_start <=
                regs_q[src_pkg::I_CLP_VST][4:0];            // [RULE11]
            stby_cfg_q.clamp_vert_count <=
                regs_q[src_pkg::I_CLP_VNUM][1:0];           // [RULE12]
        end
    end

    assign clamp_vert_start_out = stby_cfg_q.clamp_vert_start;
    assign clamp_vert_count_out = stby_cfg_q.clamp_vert_count;

    // ****************************************************************
    // immediate fields: black level
    // ****************************************************************
    logic [9:0] blk_code;

    assign blk_code = {regs_q[src_pkg::I_BLK_HI][1:0],
        regs_q[src_pkg::I_BLK_LO]};

    // scaled to output digits; follows the write on the next edge
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            black_offset_out <= 12'h000;
        end else if (readout_12bit_in) begin
            black_offset_out <=
                {blk_code, 2'b00};                         // [RULE13] [RULE16]
        end else begin
            black_offset_out <= {2'b00, blk_code};          // [RULE13]
        end
    end

    // ****************************************************************
    // sync pins
    // ****************************************************************
    logic [1:0] vs_sel;
    logic [1:0] hs_sel;
    logic vs_active;
    logic hs_active;

    assign vs_sel = regs_q[src_pkg::I_SYNC_SEL][src_pkg::SEL_VS_LSB +: 2];
    assign hs_sel = regs_q[src_pkg::I_SYNC_SEL][src_pkg::SEL_HS_LSB +: 2];

    // vertical pulse counts line starts after the frame start
    src_pulse_gen #(
        .BASE(src_pkg::VS_BASE_LINES)
    ) u_vs_pulse (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .start_in(frame_start_in),
        .tick_in(line_start_in),
        .width_code_in(
            regs_q[src_pkg::I_VS_LEN][src_pkg::LEN_LSB +: 2]),
        .active_out(vs_active)
    );                                                   // [RULE9]

    // horizontal pulse counts device clocks
    src_pulse_gen #(
        .BASE(src_pkg::HS_BASE_CLKS)
    ) u_hs_pulse (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .start_in(line_start_in),
        .tick_in(1'b1),
        .width_code_in(
            regs_q[src_pkg::I_HS_LEN][src_pkg::LEN_LSB +: 2]),
        .active_out(hs_active)
    );                                                   // [RULE10]

    // pulses are active low; idle level high; unlisted select is low
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            vsync_pin_out <= 1'b0;
            hsync_pin_out <= 1'b0;
        end else begin
            vsync_pin_out <= (vs_sel == src_pkg::PIN_SEL_SYNC) ?
                !vs_active : 1'b0;                          // [RULE5]
            hsync_pin_out <= (hs_sel == src_pkg::PIN_SEL_SYNC) ?
                !hs_active : 1'b0;                          // [RULE6]
        end
    end

    // only code 0 drives; all other codes leave the pin floating
    assign vsync_pin_oe_out =
        (stby_cfg_q.vsync_pin_drive == src_pkg::PIN_DRV_OUT); // [RULE7]
    assign hsync_pin_oe_out =
        (stby_cfg_q.hsync_pin_drive == src_pkg::PIN_DRV_OUT); // [RULE8]

endmodule // src_readout_regs

// >>> rtl/src_pkg.sv
package src_pkg;

    // ****************************************************************
    // register map: byte addresses and storage indices
    // ****************************************************************
    localparam int NUM_REGS = 23;
    localparam int IDX_W = 5;

    localparam logic [4:0] I_HST_LO = 5'h00;
    localparam logic [4:0] I_HST_HI = 5'h01;
    localparam logic [4:0] I_HWID_LO = 5'h02;
    localparam logic [4:0] I_HWID_HI = 5'h03;
    localparam logic [4:0] I_VST_LO = 5'h04;
    localparam logic [4:0] I_VST_HI = 5'h05;
    localparam logic [4:0] I_VHGT_LO = 5'h06;
    localparam logic [4:0] I_VHGT_HI = 5'h07;
    localparam logic [4:0] I_ST_B0 = 5'h08;
    localparam logic [4:0] I_ST_B1 = 5'h09;
    localparam logic [4:0] I_ST_B2 = 5'h0A;
    localparam logic [4:0] I_GAIN_LO = 5'h0B;
    localparam logic [4:0] I_GAIN_HI = 5'h0C;
    localparam logic [4:0] I_SYNC_SEL = 5'h0D;
    localparam logic [4:0] I_SYNC_DRV = 5'h0E;
    localparam logic [4:0] I_VS_LEN = 5'h0F;
    localparam logic [4:0] I_HS_LEN = 5'h10;
    localparam logic [4:0] I_CLP_VST = 5'h11;
    localparam logic [4:0] I_CLP_VNUM = 5'h12;
    localparam logic [4:0] I_BLK_LO = 5'h13;
    localparam logic [4:0] I_BLK_HI = 5'h14;
    localparam logic [4:0] I_TUNE_A = 5'h15;
    localparam logic [4:0] I_TUNE_B = 5'h16;

    localparam logic [15:0] REG_ADDR [0:NUM_REGS-1] = '{
        16'h3040, 16'h3041, 16'h3042, 16'h3043, 16'h3044, 16'h3045,
        16'h3046, 16'h3047, 16'h3050, 16'h3051, 16'h3052, 16'h3090,
        16'h3091, 16'h30C0, 16'h30C1, 16'h30CC, 16'h30CD, 16'h30D9,
        16'h30DA, 16'h30E2, 16'h30E3, 16'h32D4, 16'h32EC};

    // reset value of every byte, fixed bits included
    localparam logic [7:0] REG_RST [0:NUM_REGS-1] = '{
        8'h00, 8'h00, 8'h18, 8'h0F, 8'h00, 8'h00, 8'h20, 8'h11,
        8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2A, 8'h0F, 8'h00,
        8'h00, 8'h06, 8'h02, 8'h32, 8'h00, 8'h20, 8'hA0};

    // writable bits; the others keep their fixed value
    localparam logic [7:0] REG_MASK [0:NUM_REGS-1] = '{
        8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'h1F,
        8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h01, 8'h0F, 8'h0F, 8'h30,
        8'h30, 8'h1F, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'hFF};

    // ****************************************************************
    // field positions and codes
    // ****************************************************************
    localparam int SEL_VS_LSB = 0;
    localparam int SEL_HS_LSB = 2;
    localparam int LEN_LSB = 4;
    localparam logic [1:0] PIN_SEL_LOW = 2'h0;
    localparam logic [1:0] PIN_SEL_SYNC = 2'h2;
    localparam logic [1:0] PIN_DRV_OUT = 2'h0;
    localparam logic [1:0] PIN_DRV_HIZ = 2'h3;

    // ****************************************************************
    // timing and scaling
    // ****************************************************************
    localparam int VS_BASE_LINES = 1;
    localparam int HS_BASE_CLKS = 16;
    localparam int PULSE_CNT_W = 8;
    localparam logic [8:0] GAIN_CODE_MAX = 9'h0F0;
    localparam logic [1:0] GAIN_TENTHS_PER_STEP = 2'h3;
    localparam int BLK_SHIFT_12BIT = 2;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [12:0] hcrop_start;
        logic [12:0] hcrop_width;
        logic [12:0] vcrop_start;
        logic [12:0] vcrop_height;
        logic [19:0] storage_time;
        logic [8:0] gain_code;
    } src_frame_cfg_t;

    typedef struct packed {
        logic [1:0] vsync_pin_drive;
        logic [1:0] hsync_pin_drive;
        logic [4:0] clamp_vert_start;
        logic [1:0] clamp_vert_count;
    } src_standby_cfg_t;

    localparam src_frame_cfg_t FRAME_CFG_RST = '{
        hcrop_start: 13'h0000, hcrop_width: 13'h0F18,
        vcrop_start: 13'h0000, vcrop_height: 13'h1120,
        storage_time: 20'h00066, gain_code: 9'h000};

    localparam src_standby_cfg_t STBY_CFG_RST = '{
        vsync_pin_drive: 2'h3, hsync_pin_drive: 2'h3,
        clamp_vert_start: 5'h06, clamp_vert_count: 2'h2};

endpackage

// >>> rtl/src_pulse_gen.sv
`timescale 1ns/10ps
// ********************************************************************
// sync pulse stretcher
// ********************************************************************
module src_pulse_gen #(
    parameter int BASE = 1                      // width of code 0 in ticks
) (
    input wire logic clk_in,                    // device clock
    input wire logic nrst_in,                   // async reset, active low
    input wire logic start_in,                  // pulse start
    input wire logic tick_in,                   // width unit event
    input wire logic [1:0] width_code_in,       // width = BASE << code
    output logic active_out                     // high while pulse lasts
);

    logic [src_pkg::PULSE_CNT_W-1:0] cnt_q;
    logic [src_pkg::PULSE_CNT_W-1:0] width;

    // width read live so a new code hits the next pulse
    assign width = src_pkg::PULSE_CNT_W'(BASE) << width_code_in;

    // start reloads even mid-pulse, so a short frame merges two into one longer pulse
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= '0;
        end else if (start_in) begin
            cnt_q <= width;
        end else if (tick_in && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign active_out = (cnt_q != '0);

endmodule // src_pulse_gen

// >>> rtl/src_gain_stage.sv
`timescale 1ns/10ps
// ********************************************************************
// gain pipeline: applied two frames after it is latched
// ********************************************************************
module src_gain_stage (
    input wire logic clk_in,                    // device clock
    input wire logic nrst_in,                   // async reset, active low
    input wire logic frame_start_in,            // frame boundary pulse
    input wire logic [8:0] gain_latched_in,     // code taken at boundary
    output logic [8:0] gain_code_out,           // code used on output
    output logic [9:0] gain_tenth_db_out        // gain in 0.1 dB units
);

    logic [8:0] held_q;
    logic [9:0] tenth_d;

    // code to tenths of a dB, codes above the top clip to 72.0 dB
    function automatic logic [9:0] code_to_tenths(input logic [8:0] c);
        logic [8:0] lim;
        lim = (c > src_pkg::GAIN_CODE_MAX) ? src_pkg::GAIN_CODE_MAX : c;
        return 10'(lim) * 10'(src_pkg::GAIN_TENTHS_PER_STEP);
    endfunction

    assign tenth_d = code_to_tenths(held_q);   // [RULE4]

    // second boundary moves the held code to the output frame
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            held_q <= 9'h000;
            gain_code_out <= 9'h000;
            gain_tenth_db_out <= 10'h000;
        end else if (frame_start_in) begin
            held_q <= gain_latched_in;
            gain_code_out <= held_q;            // [RULE19]
            gain_tenth_db_out <= tenth_d;       // [RULE4]
        end
    end

endmodule // src_gain_stage

// >>> test/src_readout_regs_chk.sv
`timescale 1ns/10ps
// ********
// port checker
// ********
module src_readout_regs_chk (
    input wire logic clk_in, // device clock
    input wire logic nrst_in, // async reset
    input wire logic reg_rd_in, // read strobe
    input wire logic reg_wr_in, // write strobe
    input wire logic [15:0] reg_addr_in, // byte address
    input wire logic [7:0] reg_wdata_in, // write byte
    input wire logic [7:0] reg_rdata_out, // read byte
    input wire logic reg_hit_out, // read was mapped
    input wire logic standby_in, // standby level
    input wire logic readout_12bit_in, // 12-bit mode
    input wire logic frame_start_in, // frame boundary
    input wire src_pkg::src_frame_cfg_t frame_cfg_out, // frame set
    input wire logic [8:0] gain_code_out, // output gain code
    input wire logic [9:0] gain_tenth_db_out, // gain, 0.1 dB
    input wire logic [11:0] black_offset_out, // offset digits
    input wire logic vsync_pin_out, // vertical pin
    input wire logic hsync_pin_out, // horizontal pin
    input wire logic vsync_pin_oe_out // vertical enable
);
    logic mapped;

    // own decode, apart from the design's
    always_comb begin
        mapped = 1'b0;
        for (int i = 0; i < src_pkg::NUM_REGS; i++) begin
            if (reg_addr_in == src_pkg::REG_ADDR[i]) mapped = 1'b1;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_unmapped_read: assert property (
        reg_rd_in && !mapped |=> reg_rdata_out == 8'h00 && !reg_hit_out)
        else $error("unmapped read answered");
    a_mapped_hit: assert property (
        reg_rd_in && mapped |=> reg_hit_out)
        else $error("mapped read without hit");
    a_read_holds: assert property (
        !reg_rd_in |=> $stable(reg_rdata_out) && $stable(reg_hit_out))
        else $error("read data moved");
    a_frame_hold: assert property (
        !frame_start_in |=> $stable(frame_cfg_out))
        else $error("frame settings moved mid-frame");
    a_gain_steady: assert property (
        !frame_start_in |=> $stable(gain_code_out))
        else $error("output gain moved mid-frame");
    a_gain_scale: assert property (
        gain_tenth_db_out == 10'((gain_code_out > 9'h0F0 ? 9'h0F0
            : gain_code_out) * 3))
        else $error("gain scale wrong");
    a_offset_scale: assert property (
        $past(readout_12bit_in) ? black_offset_out[1:0] == 2'h0
            : black_offset_out[11:10] == 2'h0)
        else $error("offset scale wrong");
    a_vs_sel_low: assert property (
        reg_wr_in && reg_addr_in == 16'h30C0 && reg_wdata_in[1:0] == 2'h0
        |-> ##2 !vsync_pin_out) else $error("vertical pin not held low");
    a_hs_sel_low: assert property (
        reg_wr_in && reg_addr_in == 16'h30C0 && reg_wdata_in[3:2] == 2'h0
        |-> ##2 !hsync_pin_out) else $error("horizontal pin not held low");
    a_drive_standby: assert property (
        $changed(vsync_pin_oe_out) |-> $past(standby_in, 2)
        && !$past(standby_in)) else $error("drive moved off release");
endmodule // src_readout_regs_chk

bind src_readout_regs src_readout_regs_chk chk_u (.*);

// >>> test/src_host_model.sv
`timescale 1ns/10ps
// ********
// host of the byte port
// ********
module src_host_model (
    input wire logic clk_in, // device clock
    input wire logic [7:0] rdata_in, // read byte
    input wire logic hit_in, // read was mapped
    output logic wr_out, // write strobe
    output logic rd_out, // read strobe
    output logic [15:0] addr_out, // byte address
    output logic [7:0] wdata_out // write byte
);
    // idle bus shows inverted leftovers
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 16'hFFFF;
        wdata_out = 8'hFF;
    end

    // one byte write over one edge
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = v;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~v;
    endtask

    // one byte read, answer a cycle later
    task automatic rd(input logic [15:0] a, output logic [7:0] v,
                      output logic h);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        addr_out = ~a;
        v = rdata_in;
        h = hit_in;
    endtask

    // clamp window per readout mode
    task automatic clamp_mode(input logic binning);
        wr(16'h30D9, binning ? 8'h02 : 8'h06);
        wr(16'h30DA, binning ? 8'h01 : 8'h02);
    endtask
endmodule // src_host_model

// >>> test/tb_src_readout_regs.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ********
// register bank bench
// ********
module tb_src_readout_regs;
    logic clk_in, nrst_in, standby_in, readout_12bit_in;
    logic frame_start_in, line_start_in, reg_wr_in, reg_rd_in;
    logic [15:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, d, rv, mv;
    logic reg_hit_out, h, crop_misaligned_out, vsync_pin_out;
    logic vsync_pin_oe_out, hsync_pin_out, hsync_pin_oe_out;
    src_pkg::src_frame_cfg_t frame_cfg_out;
    logic [8:0] gain_code_out, g;
    logic [9:0] gain_tenth_db_out;
    logic [11:0] black_offset_out;
    logic [4:0] clamp_vert_start_out;
    logic [1:0] clamp_vert_count_out;
    logic [8:0] stby;
    int err_total = 0, checked = 0, hl, vl, vn;
    localparam src_pkg::src_frame_cfg_t NCFG = '{13'h0000, 13'h0000,
        13'h0102, 13'h0000, 20'h00000, 9'h005};
    localparam logic [8:0] GC [0:2] = '{9'h0F0, 9'h1FF, 9'h001};

    src_readout_regs dut_u (.*);
    src_host_model host_u (.clk_in, .rdata_in(reg_rdata_out),
        .hit_in(reg_hit_out), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
        .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));

    // standby copies in one word
    assign stby = {vsync_pin_oe_out, hsync_pin_oe_out, clamp_vert_start_out,
        clamp_vert_count_out};

    // 40 MHz device clock
    initial clk_in = 1'b0;
    always #12.5 clk_in = ~clk_in;

    task automatic print_verdict();
        $display("checked=%0d errors=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        host_u.rd(a, d, h);
        `CHK({h, d}, {1'b1, e})
    endtask

    task automatic frame();
        @(negedge clk_in) frame_start_in = 1'b1;
        @(negedge clk_in) frame_start_in = 0;
        repeat (2) @(negedge clk_in);
    endtask

    // 200-clock line, fits the widest pulse
    task automatic line();
        @(negedge clk_in);
        vl = (vsync_pin_out === 1'b0);
        hl = 0;
        line_start_in = 1'b1;
        @(negedge clk_in) line_start_in = 1'b0;
        repeat (198) begin
            @(negedge clk_in);
            if (hsync_pin_out === 1'b0) hl++;
        end
    endtask

    // ********
    // main sequence
    // ********
    initial begin
        nrst_in = 1'b0;
        standby_in = 1'b1;
        readout_12bit_in = 1'b0;
        frame_start_in = 1'b0;
        line_start_in = 1'b0;
        repeat (5) @(negedge clk_in);
        nrst_in = 1'b1;
        for (int i = 0; i < 23; i++) begin
            rv = src_pkg::REG_RST[i];
            mv = src_pkg::REG_MASK[i];
            rchk(src_pkg::REG_ADDR[i], rv);
            host_u.wr(src_pkg::REG_ADDR[i], 8'hFF);
            rchk(src_pkg::REG_ADDR[i], mv | rv);
            host_u.wr(src_pkg::REG_ADDR[i], 8'h00);
            rchk(src_pkg::REG_ADDR[i], rv & ~mv);
        end
        `CHK(black_offset_out, 12'h000)
        host_u.wr(16'h3048, 8'h55);
        host_u.rd(16'h3048, d, h);
        `CHK({h, d}, 9'h000)
        // standby fields wait for the release
        `CHK(stby, 9'h01A)
        host_u.clamp_mode(1'b1);
        host_u.wr(16'h30C1, 8'h00);
        @(negedge clk_in) standby_in = 1'b0;
        repeat (2) @(negedge clk_in);
        `CHK(stby, 9'h189)
        standby_in = 1'b1;
        host_u.wr(16'h30C1, 8'h0F);
        @(negedge clk_in) standby_in = 1'b0;
        repeat (2) @(negedge clk_in);
        `CHK(stby, 9'h009)
        // frame fields at the boundary, gain two frames later
        host_u.wr(16'h3044, 8'h02);
        host_u.wr(16'h3045, 8'h01);
        host_u.wr(16'h3090, 8'h05);
        `CHK(frame_cfg_out, src_pkg::FRAME_CFG_RST)
        `CHK(crop_misaligned_out, 1'b0)
        frame();
        `CHK(frame_cfg_out, NCFG)
        `CHK(crop_misaligned_out, 1'b1)
        frame();
        `CHK(gain_code_out, 9'h000)
        frame();
        `CHK(gain_code_out, 9'h005)
        foreach (GC[j]) begin
            host_u.wr(16'h3090, GC[j][7:0]);
            host_u.wr(16'h3091, {7'h00, GC[j][8]});
            repeat (3) frame();
            g = GC[j] > 9'h0F0 ? 9'h0F0 : GC[j];
            `CHK(gain_code_out, GC[j])
            `CHK(gain_tenth_db_out, 10'(g * 3))
        end
        host_u.wr(16'h30E2, 8'h34);
        host_u.wr(16'h30E3, 8'h02);
        @(negedge clk_in);
        `CHK(black_offset_out, 12'h234)
        readout_12bit_in = 1'b1;
        repeat (2) @(negedge clk_in);
        `CHK(black_offset_out, 12'h8D0)
        // each width code, both pins
        host_u.wr(16'h30C0, 8'h0A);
        for (int c = 0; c < 4; c++) begin
            host_u.wr(16'h30CC, 8'(c << 4));
            host_u.wr(16'h30CD, 8'(c << 4));
            frame();
            vn = 0;
            repeat (10) begin
                line();
                vn += vl;
            end
            `CHK(hl, 16 << c)
            `CHK(vn, 1 << c)
        end
        `CHK({vsync_pin_out, hsync_pin_out}, 2'b11)
        host_u.wr(16'h30C0, 8'h00);
        line();
        `CHK({vsync_pin_out, hsync_pin_out}, 2'b00)
        print_verdict();
    end

    // cut a hang short
    initial begin
        repeat (60000) @(posedge clk_in);
        err_total++;
        print_verdict();
    end
endmodule // tb_src_readout_regs
